// >>> hw/atc_pkg.sv
package atc_pkg;

	// I/O register offsets
	localparam logic [5:0] ADDR_ASYNC_TIMER_STATUS = 6'h22;
	localparam logic [5:0] ADDR_COMPARE_VALUE = 6'h23;
	localparam logic [5:0] ADDR_COUNT_VALUE = 6'h24;
	localparam logic [5:0] ADDR_TIMER_CONTROL = 6'h25;
	localparam logic [5:0] ADDR_TIMER_FLAGS = 6'h38;
	localparam logic [5:0] ADDR_TIMER_MASK = 6'h39;

	// Reset values
	localparam logic [7:0] RST_ASYNC_TIMER_STATUS = 8'h00;
	localparam logic [7:0] RST_COMPARE_VALUE = 8'h00;
	localparam logic [7:0] RST_COUNT_VALUE = 8'h00;
	localparam logic [7:0] RST_TIMER_CONTROL = 8'h00;
	localparam logic [1:0] RST_TIMER_FLAGS = 2'h0;
	localparam logic [1:0] RST_TIMER_MASK = 2'h0;

	// Status register bit positions
	localparam int STS_ASYNC_SELECT = 3;
	localparam int STS_COUNT_BUSY = 2;
	localparam int STS_COMPARE_BUSY = 1;
	localparam int STS_CONTROL_BUSY = 0;

	// Control register field positions
	localparam int CTL_WGM_LOW = 6;
	localparam int CTL_COM_HI = 5;
	localparam int CTL_COM_LO = 4;
	localparam int CTL_WGM_HIGH = 3;
	localparam int CTL_CS_HI = 2;
	localparam int CTL_CS_LO = 0;

	// Flag and mask register bit positions
	localparam int FLG_OVERFLOW = 0;
	localparam int FLG_COMPARE = 1;

	// Waveform generation modes
	localparam logic [1:0] WGM_NORMAL = 2'h0;
	localparam logic [1:0] WGM_CTC = 2'h2;
	localparam logic [1:0] WGM_FAST_PWM = 2'h3;

	// Compare output modes
	localparam logic [1:0] COM_OFF = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR = 2'h2;
	localparam logic [1:0] COM_SET = 2'h3;

	// Counter limits
	localparam logic [7:0] COUNT_MAX = 8'hFF;
	localparam logic [7:0] COUNT_BOTTOM = 8'h00;

	// Prescaler taps, one mask per clock-select code
	localparam int PRESCALE_WIDTH = 10;
	localparam logic [2:0] CS_STOPPED = 3'h0;
	localparam logic [9:0] PRE_MASK_1 = 10'h000;
	localparam logic [9:0] PRE_MASK_8 = 10'h007;
	localparam logic [9:0] PRE_MASK_32 = 10'h01F;
	localparam logic [9:0] PRE_MASK_64 = 10'h03F;
	localparam logic [9:0] PRE_MASK_128 = 10'h07F;
	localparam logic [9:0] PRE_MASK_256 = 10'h0FF;
	localparam logic [9:0] PRE_MASK_1024 = 10'h3FF;

endpackage

// >>> hw/atc_prescaler.sv
`timescale 1ns/10ps
`default_nettype none

module atc_prescaler (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_src_tick,
	input wire logic [2:0] i_clock_select,
	output logic o_tick
);

	logic [9:0] pre_count;
	logic [9:0] tap_mask;

	// Tap mask for each clock-select code
	function automatic logic [9:0] tap_of(input logic [2:0] cs);
		case (cs)
			3'h1: tap_of = atc_pkg::PRE_MASK_1;
			3'h2: tap_of = atc_pkg::PRE_MASK_8;
			3'h3: tap_of = atc_pkg::PRE_MASK_32;
			3'h4: tap_of = atc_pkg::PRE_MASK_64;
			3'h5: tap_of = atc_pkg::PRE_MASK_128;
			3'h6: tap_of = atc_pkg::PRE_MASK_256;
			3'h7: tap_of = atc_pkg::PRE_MASK_1024;
			default: tap_of = atc_pkg::PRE_MASK_1;
		endcase
	endfunction

	// Divided tick, none while stopped
	assign tap_mask = tap_of(i_clock_select);
	assign o_tick = (i_clock_select != atc_pkg::CS_STOPPED) && i_src_tick &&
		((pre_count & tap_mask) == tap_mask);

	// Free prescale counter on source ticks
	always_ff @(posedge i_clk) begin
		if (!i_reset_n || i_clock_select == atc_pkg::CS_STOPPED) begin
			pre_count <= 10'h000;
		end else if (i_src_tick) begin
			pre_count <= pre_count + 10'h001;
		end
	end

endmodule

`default_nettype wire

// >>> hw/atc_timer.sv
// Summary of operation
// - Compare-match flag sets when counter hits compare value; enabled flag raises request.
// - Compare value below count misses match; counter wraps through 0xFF to 0x00.
// - Clear-on-compare mode with output mode 1 toggles waveform on each match.
// - Waveform drives pin only while the pin direction is output.
// - Toggle frequency is io clock over 2*N*(1+compare); zero gives clock/2.
// - Overflow flag sets in the timer tick where counter steps MAX to 0x00.
// - Generation mode 3 is fast PWM, counting BOTTOM to MAX, then BOTTOM.
// - Fast PWM non-inverting: clear output on match, set at BOTTOM.
// - Fast PWM inverting: set output on match, clear at BOTTOM.
// - Fast PWM: counter at MAX clears on the next timer tick.
// - Clock select 000 stops; 001..111 divide the selected clock source by 1..1024.
// - Async select low clocks from io clock; high from timer oscillator input.
// - Async counter write sets count busy until counter loads from holding register.
// - Async compare write sets compare busy until compare loads from holding register.
// - Async control write sets control busy until control loads from holding register.
// - Counter reads live value; compare and control read their holding registers.
`timescale 1ns/10ps
`default_nettype none

module atc_timer (
	input wire logic I_REF_CLK,
	input wire logic I_RESET_N,
	input wire logic [5:0] I_IO_ADDR,
	input wire logic I_IO_WRITE,
	input wire logic I_IO_READ,
	input wire logic [7:0] I_IO_WDATA,
	output logic [7:0] O_IO_RDATA,
	input wire logic I_TIMER_OSC_INPUT,
	input wire logic I_PIN_DIRECTION,
	output logic O_WAVEFORM_OUT,
	output logic O_WAVEFORM_OE,
	output logic O_COMPARE_IRQ,
	output logic O_OVERFLOW_IRQ
);

	// Registers
	logic async_select;
	logic count_busy;
	logic compare_busy;
	logic control_busy;
	logic [7:0] count_value_reg;
	logic [7:0] count_hold;
	logic [7:0] compare_value_reg;
	logic [7:0] compare_hold;
	logic [7:0] timer_control_reg;
	logic [7:0] control_hold;
	logic compare_match_flag;
	logic overflow_flag;
	logic [1:0] irq_mask;
	logic waveform_out;
	logic osc_prev;

	// Decoded wires
	logic wr_status;
	logic wr_compare;
	logic wr_count;
	logic wr_control;
	logic wr_flags;
	logic wr_mask;
	logic osc_rise;
	logic src_tick;
	logic timer_tick;
	logic count_load;
	logic step;
	logic [1:0] waveform_gen_mode;
	logic [1:0] compare_output_mode;
	logic [2:0] clock_select;
	logic is_ctc;
	logic is_pwm;
	logic at_max;
	logic match;
	logic match_event;
	logic wrap_event;
	logic [7:0] next_count;
	logic next_waveform;
	logic next_compare_flag;
	logic next_overflow_flag;
	logic [7:0] status_view;
	logic [7:0] read_mux;

	// Register write strobes
	assign wr_status = I_IO_WRITE && I_IO_ADDR == atc_pkg::ADDR_ASYNC_TIMER_STATUS;
	assign wr_compare = I_IO_WRITE && I_IO_ADDR == atc_pkg::ADDR_COMPARE_VALUE;
	assign wr_count = I_IO_WRITE && I_IO_ADDR == atc_pkg::ADDR_COUNT_VALUE;
	assign wr_control = I_IO_WRITE && I_IO_ADDR == atc_pkg::ADDR_TIMER_CONTROL;
	assign wr_flags = I_IO_WRITE && I_IO_ADDR == atc_pkg::ADDR_TIMER_FLAGS;
	assign wr_mask = I_IO_WRITE && I_IO_ADDR == atc_pkg::ADDR_TIMER_MASK;

	// Clock source: every io cycle or each oscillator rising edge
	assign osc_rise = I_TIMER_OSC_INPUT && !osc_prev;
	assign src_tick = async_select ? osc_rise : 1'b1;

	// Control fields
	assign waveform_gen_mode = {timer_control_reg[atc_pkg::CTL_WGM_HIGH], timer_control_reg[atc_pkg::CTL_WGM_LOW]};
	assign compare_output_mode = timer_control_reg[atc_pkg::CTL_COM_HI:atc_pkg::CTL_COM_LO];
	assign clock_select = timer_control_reg[atc_pkg::CTL_CS_HI:atc_pkg::CTL_CS_LO];
	assign is_ctc = waveform_gen_mode == atc_pkg::WGM_CTC;
	assign is_pwm = waveform_gen_mode == atc_pkg::WGM_FAST_PWM;

	// Prescaler producing the timer tick
	atc_prescaler u_prescaler (
		.i_clk(I_REF_CLK),
		.i_reset_n(I_RESET_N),
		.i_src_tick(src_tick),
		.i_clock_select(clock_select),
		.o_tick(timer_tick)
	);

	// Counter load has precedence over counting
	assign count_load = async_select ? (count_busy && osc_rise && !wr_count) : wr_count;
	assign step = timer_tick && !count_load;

	// Compare and wrap events
	assign at_max = count_value_reg == atc_pkg::COUNT_MAX;
	assign match = count_value_reg == compare_value_reg;
	assign match_event = step && match;
	assign wrap_event = step && at_max && !(is_ctc && match && !at_max);

	// Next counter value
	always_comb begin
		next_count = count_value_reg;
		if (count_load) begin
			next_count = async_select ? count_hold : I_IO_WDATA;
		end else if (step) begin
			if (is_ctc && match) begin
				next_count = atc_pkg::COUNT_BOTTOM;
			end else if (at_max) begin
				next_count = atc_pkg::COUNT_BOTTOM;
			end else begin
				next_count = count_value_reg + 8'h01;
			end
		end
	end

	// Next waveform level; BOTTOM wins over match in fast PWM
	always_comb begin
		next_waveform = waveform_out;
		if (is_pwm) begin
			if (step && at_max && compare_output_mode == atc_pkg::COM_CLEAR) begin
				next_waveform = 1'b1;
			end else if (step && at_max && compare_output_mode == atc_pkg::COM_SET) begin
				next_waveform = 1'b0;
			end else if (match_event && compare_output_mode == atc_pkg::COM_CLEAR) begin
				next_waveform = 1'b0;
			end else if (match_event && compare_output_mode == atc_pkg::COM_SET) begin
				next_waveform = 1'b1;
			end
		end else if (match_event) begin
			case (compare_output_mode)
				atc_pkg::COM_TOGGLE: next_waveform = !waveform_out;
				atc_pkg::COM_CLEAR: next_waveform = 1'b0;
				atc_pkg::COM_SET: next_waveform = 1'b1;
				default: next_waveform = waveform_out;
			endcase
		end
	end

	// Flags: a set in the clear cycle wins
	assign next_compare_flag = match_event ||
		(compare_match_flag && !(wr_flags && I_IO_WDATA[atc_pkg::FLG_COMPARE]));
	assign next_overflow_flag = wrap_event ||
		(overflow_flag && !(wr_flags && I_IO_WDATA[atc_pkg::FLG_OVERFLOW]));

	// Read view
	assign status_view = {4'h0, async_select, count_busy, compare_busy, control_busy};
	assign read_mux =
		(I_IO_ADDR == atc_pkg::ADDR_ASYNC_TIMER_STATUS) ? status_view :
		(I_IO_ADDR == atc_pkg::ADDR_COUNT_VALUE) ? count_value_reg :
		(I_IO_ADDR == atc_pkg::ADDR_COMPARE_VALUE) ? compare_hold :
		(I_IO_ADDR == atc_pkg::ADDR_TIMER_CONTROL) ? control_hold :
		(I_IO_ADDR == atc_pkg::ADDR_TIMER_FLAGS) ? {6'h00, compare_match_flag, overflow_flag} :
		(I_IO_ADDR == atc_pkg::ADDR_TIMER_MASK) ? {6'h00, irq_mask} : 8'h00;

	// Async select and oscillator edge history
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RESET_N) begin
			async_select <= atc_pkg::RST_ASYNC_TIMER_STATUS[atc_pkg::STS_ASYNC_SELECT];
			osc_prev <= 1'b0;
		end else begin
			if (wr_status) begin
				async_select <= I_IO_WDATA[atc_pkg::STS_ASYNC_SELECT];
			end
			osc_prev <= I_TIMER_OSC_INPUT;
		end
	end

	// Busy flags: a write on the load edge keeps the flag set
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RESET_N) begin
			count_busy <= atc_pkg::RST_ASYNC_TIMER_STATUS[atc_pkg::STS_COUNT_BUSY];
			compare_busy <= atc_pkg::RST_ASYNC_TIMER_STATUS[atc_pkg::STS_COMPARE_BUSY];
			control_busy <= atc_pkg::RST_ASYNC_TIMER_STATUS[atc_pkg::STS_CONTROL_BUSY];
		end else begin
			count_busy <= (async_select && wr_count) || (count_busy && !osc_rise);
			compare_busy <= (async_select && wr_compare) || (compare_busy && !osc_rise);
			control_busy <= (async_select && wr_control) || (control_busy && !osc_rise);
		end
	end

	// Holding registers take every write
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RESET_N) begin
			count_hold <= atc_pkg::RST_COUNT_VALUE;
			compare_hold <= atc_pkg::RST_COMPARE_VALUE;
			control_hold <= atc_pkg::RST_TIMER_CONTROL;
		end else begin
			if (wr_count) begin
				count_hold <= I_IO_WDATA;
			end
			if (wr_compare) begin
				compare_hold <= I_IO_WDATA;
			end
			if (wr_control) begin
				control_hold <= I_IO_WDATA;
			end
		end
	end

	// Live compare and control: direct when synchronous, on oscillator edge when async
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RESET_N) begin
			compare_value_reg <= atc_pkg::RST_COMPARE_VALUE;
			timer_control_reg <= atc_pkg::RST_TIMER_CONTROL;
		end else begin
			if (!async_select && wr_compare) begin
				compare_value_reg <= I_IO_WDATA;
			end else if (async_select && compare_busy && osc_rise && !wr_compare) begin
				compare_value_reg <= compare_hold;
			end
			if (!async_select && wr_control) begin
				timer_control_reg <= I_IO_WDATA;
			end else if (async_select && control_busy && osc_rise && !wr_control) begin
				timer_control_reg <= control_hold;
			end
		end
	end

	// Counter, waveform and flags
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RESET_N) begin
			count_value_reg <= atc_pkg::RST_COUNT_VALUE;
			waveform_out <= 1'b0;
			compare_match_flag <= atc_pkg::RST_TIMER_FLAGS[atc_pkg::FLG_COMPARE];
			overflow_flag <= atc_pkg::RST_TIMER_FLAGS[atc_pkg::FLG_OVERFLOW];
			irq_mask <= atc_pkg::RST_TIMER_MASK;
		end else begin
			count_value_reg <= next_count;
			waveform_out <= next_waveform;
			compare_match_flag <= next_compare_flag;
			overflow_flag <= next_overflow_flag;
			if (wr_mask) begin
				irq_mask <= I_IO_WDATA[1:0];
			end
		end
	end

	// Registered outputs
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RESET_N) begin
			O_IO_RDATA <= 8'h00;
			O_WAVEFORM_OUT <= 1'b0;
			O_WAVEFORM_OE <= 1'b0;
			O_COMPARE_IRQ <= 1'b0;
			O_OVERFLOW_IRQ <= 1'b0;
		end else begin
			if (I_IO_READ) begin
				O_IO_RDATA <= read_mux;
			end
			O_WAVEFORM_OUT <= next_waveform;
			O_WAVEFORM_OE <= I_PIN_DIRECTION && compare_output_mode != atc_pkg::COM_OFF;
			O_COMPARE_IRQ <= next_compare_flag && irq_mask[atc_pkg::FLG_COMPARE];
			O_OVERFLOW_IRQ <= next_overflow_flag && irq_mask[atc_pkg::FLG_OVERFLOW];
		end
	end

	// Checks
	default clocking cb @(posedge I_REF_CLK);
	endclocking
	default disable iff (!I_RESET_N);

	sequence s_ctc_match;
		step && is_ctc && match;
	endsequence

	sequence s_pwm_max;
		step && is_pwm && at_max;
	endsequence

	property p_ctc_clear;
		s_ctc_match |=> count_value_reg == 8'h00;
	endproperty
	a_ctc_clear: assert property (p_ctc_clear) else $error("counter not cleared after match");

	property p_compare_flag;
		s_ctc_match |=> compare_match_flag ##1 compare_match_flag || $past(wr_flags);
	endproperty
	a_compare_flag: assert property (p_compare_flag) else $error("compare flag not set");

	property p_toggle;
		s_ctc_match and (compare_output_mode == atc_pkg::COM_TOGGLE) |=> O_WAVEFORM_OUT != $past(O_WAVEFORM_OUT);
	endproperty
	a_toggle: assert property (p_toggle) else $error("waveform did not toggle");

	property p_overflow;
		step && at_max && !is_ctc |=> overflow_flag && count_value_reg == 8'h00;
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow flag missing at wrap");

	property p_missed_match;
		step && is_ctc && count_value_reg > compare_value_reg && !at_max |=>
			count_value_reg == $past(count_value_reg) + 8'h01;
	endproperty
	a_missed_match: assert property (p_missed_match) else $error("missed match did not count on");

	property p_pwm_wrap;
		s_pwm_max |=> count_value_reg == 8'h00;
	endproperty
	a_pwm_wrap: assert property (p_pwm_wrap) else $error("fast pwm did not clear after max");

	property p_pwm_bottom;
		s_pwm_max and (compare_output_mode == atc_pkg::COM_CLEAR) |=> O_WAVEFORM_OUT;
	endproperty
	a_pwm_bottom: assert property (p_pwm_bottom) else $error("non-inverting output not set at bottom");

	property p_pwm_inverted;
		s_pwm_max and (compare_output_mode == atc_pkg::COM_SET) |=> !O_WAVEFORM_OUT;
	endproperty
	a_pwm_inverted: assert property (p_pwm_inverted) else $error("inverting output not cleared at bottom");

	property p_stopped;
		clock_select == atc_pkg::CS_STOPPED |-> !timer_tick;
	endproperty
	a_stopped: assert property (p_stopped) else $error("timer ticked while stopped");

	property p_sync_clock;
		!async_select && clock_select == 3'h1 |-> timer_tick;
	endproperty
	a_sync_clock: assert property (p_sync_clock) else $error("undivided io clock tick missing");

	property p_count_busy;
		async_select && wr_count |=> count_busy;
	endproperty
	a_count_busy: assert property (p_count_busy) else $error("count busy not set");

	property p_compare_load;
		async_select && compare_busy && osc_rise && !wr_compare |=>
			!compare_busy && compare_value_reg == $past(compare_hold);
	endproperty
	a_compare_load: assert property (p_compare_load) else $error("compare not loaded from holding");

	property p_control_busy;
		async_select && wr_control |=> control_busy;
	endproperty
	a_control_busy: assert property (p_control_busy) else $error("control busy not set");

	property p_pin_gate;
		!I_PIN_DIRECTION |=> !O_WAVEFORM_OE;
	endproperty
	a_pin_gate: assert property (p_pin_gate) else $error("pin driven while direction is input");

	property p_read_count;
		I_IO_READ && I_IO_ADDR == atc_pkg::ADDR_COUNT_VALUE |=> O_IO_RDATA == $past(count_value_reg);
	endproperty
	a_read_count: assert property (p_read_count) else $error("count read not live value");

endmodule

`default_nettype wire

// >>> tb/atc_osc_model.sv
`timescale 1ns/10ps
`default_nettype none

module atc_osc_model #(
	parameter int HALF_PERIOD = 5
) (
	input wire logic i_clk,
	input wire logic i_enable,
	input wire logic i_wave_out,
	input wire logic i_wave_oe,
	output logic o_osc,
	output logic o_pin
);
	int count = 0;
	logic osc_level = 1'b0;

	// Crystal runs while enabled and stands still while halted
	always @(posedge i_clk) begin
		if (i_enable) begin
			if (count == HALF_PERIOD - 1) begin
				count <= 0;
				osc_level <= ~osc_level;
			end else begin
				count <= count + 1;
			end
		end
	end

	// Pin has a pull-down, so it reads low whenever nothing drives it
	assign o_osc = osc_level;
	assign o_pin = i_wave_oe ? i_wave_out : 1'b0;
endmodule

`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin errors++; \
	$display("ERROR at %0t: got %h expected %h", $time, (got), (exp)); end end

module testbench;
	localparam logic [5:0] STS = atc_pkg::ADDR_ASYNC_TIMER_STATUS;
	localparam logic [5:0] CMP = atc_pkg::ADDR_COMPARE_VALUE;
	localparam logic [5:0] CNT = atc_pkg::ADDR_COUNT_VALUE;
	localparam logic [5:0] CTL = atc_pkg::ADDR_TIMER_CONTROL;
	localparam logic [5:0] FLG = atc_pkg::ADDR_TIMER_FLAGS;
	localparam logic [5:0] MSK = atc_pkg::ADDR_TIMER_MASK;
	localparam int CYCLE_LIMIT = 20000;
	logic I_REF_CLK = 1'b0;
	logic I_RESET_N = 1'b0;
	logic [5:0] I_IO_ADDR = 6'h00;
	logic I_IO_WRITE = 1'b0;
	logic I_IO_READ = 1'b0;
	logic [7:0] I_IO_WDATA = 8'h00;
	logic I_PIN_DIRECTION = 1'b0;
	logic osc_enable = 1'b0;
	wire logic osc_line;
	wire logic pin_level;
	wire logic [7:0] O_IO_RDATA;
	wire logic O_WAVEFORM_OUT;
	wire logic O_WAVEFORM_OE;
	wire logic O_COMPARE_IRQ;
	wire logic O_OVERFLOW_IRQ;
	int errors = 0;
	int n_checks = 0;
	int cycles = 0;

	atc_timer uut (.I_REF_CLK(I_REF_CLK), .I_RESET_N(I_RESET_N), .I_IO_ADDR(I_IO_ADDR),
		.I_IO_WRITE(I_IO_WRITE), .I_IO_READ(I_IO_READ), .I_IO_WDATA(I_IO_WDATA),
		.O_IO_RDATA(O_IO_RDATA), .I_TIMER_OSC_INPUT(osc_line), .I_PIN_DIRECTION(I_PIN_DIRECTION),
		.O_WAVEFORM_OUT(O_WAVEFORM_OUT), .O_WAVEFORM_OE(O_WAVEFORM_OE),
		.O_COMPARE_IRQ(O_COMPARE_IRQ), .O_OVERFLOW_IRQ(O_OVERFLOW_IRQ));

	atc_osc_model #(.HALF_PERIOD(5)) partner (.i_clk(I_REF_CLK), .i_enable(osc_enable),
		.i_wave_out(O_WAVEFORM_OUT), .i_wave_oe(O_WAVEFORM_OE), .o_osc(osc_line), .o_pin(pin_level));

	// 50 MHz clock
	initial begin
		forever #10 I_REF_CLK = ~I_REF_CLK;
	end

	// Hang guard
	always @(posedge I_REF_CLK) begin
		cycles++;
		if (cycles == CYCLE_LIMIT) begin
			errors++;
			$display("ERROR at %0t: cycles %h limit %h", $time, cycles, CYCLE_LIMIT);
			report_and_stop();
		end
	end

	task report_and_stop();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task io_write(input logic [5:0] a, input logic [7:0] d);
		@(posedge I_REF_CLK);
		#1;
		I_IO_ADDR = a;
		I_IO_WDATA = d;
		I_IO_WRITE = 1'b1;
		@(posedge I_REF_CLK);
		#1;
		I_IO_WRITE = 1'b0;
	endtask

	task io_read(input logic [5:0] a, output logic [7:0] d);
		@(posedge I_REF_CLK);
		#1;
		I_IO_ADDR = a;
		I_IO_READ = 1'b1;
		@(posedge I_REF_CLK);
		#1;
		I_IO_READ = 1'b0;
		d = O_IO_RDATA;
	endtask

	task idle(input int n);
		repeat (n) @(posedge I_REF_CLK);
		#1;
	endtask

	// Cycles until the pin level next changes
	task wait_change(output int n);
		logic v;
		v = pin_level;
		n = 0;
		while (pin_level === v && n < 5000) begin
			@(posedge I_REF_CLK);
			#1;
			n++;
		end
	endtask

	task to_rise();
		int n;
		wait_change(n);
		if (pin_level !== 1'b1) wait_change(n);
	endtask

	// No further write until every busy flag has dropped
	task wait_idle();
		logic [7:0] rd;
		int k;
		rd = 8'hFF;
		k = 0;
		while (rd[2:0] !== 3'h0 && k < 40) begin
			io_read(STS, rd);
			k++;
		end
		`CHK(rd, 8'h08)
	endtask

	task t_reset();
		logic [7:0] rd;
		logic [5:0] addrs [5];
		addrs = '{STS, CMP, CNT, CTL, 6'h3F};
		for (int i = 0; i < 5; i++) begin
			io_read(addrs[i], rd);
			`CHK(rd, 8'h00)
		end
	endtask

	task t_ctc();
		logic [7:0] a;
		logic [7:0] b;
		int n;
		io_write(CMP, 8'h03);
		io_write(CTL, 8'h19);
		idle(4);
		`CHK(O_WAVEFORM_OUT, 1'b1)
		`CHK(O_WAVEFORM_OE, 1'b0)
		`CHK(pin_level, 1'b0)
		I_PIN_DIRECTION = 1'b1;
		idle(2);
		`CHK(O_WAVEFORM_OE, 1'b1)
		wait_change(n);
		wait_change(n);
		`CHK(n, 4)
		io_write(MSK, 8'h02);
		idle(8);
		`CHK(O_COMPARE_IRQ, 1'b1)
		io_write(MSK, 8'h00);
		idle(3);
		`CHK(O_COMPARE_IRQ, 1'b0)
		io_write(CTL, 8'h18);
		io_read(CNT, a);
		idle(20);
		io_read(CNT, b);
		`CHK(b, a)
	endtask

	task t_prescale();
		int n;
		int div [7];
		div = '{1, 8, 32, 64, 128, 256, 1024};
		io_write(CMP, 8'h00);
		for (int c = 1; c < 8; c++) begin
			io_write(CTL, 8'h18);
			io_write(CNT, 8'h00);
			io_write(CTL, {5'h03, c[2:0]});
			wait_change(n);
			wait_change(n);
			`CHK(n, div[c - 1])
		end
	endtask

	task t_pwm();
		int ha;
		int la;
		int hb;
		int hi;
		io_write(CMP, 8'h40);
		io_write(CTL, 8'h69);
		to_rise();
		wait_change(ha);
		wait_change(la);
		`CHK(ha + la, 256)
		io_write(CMP, 8'h80);
		to_rise();
		wait_change(hb);
		`CHK(hb - ha, 64)
		io_write(CTL, 8'h79);
		to_rise();
		wait_change(hi);
		`CHK(hi, 256 - hb)
		io_write(MSK, 8'h01);
		idle(260);
		`CHK(O_OVERFLOW_IRQ, 1'b1)
		io_write(MSK, 8'h00);
	endtask

	task t_miss();
		logic [7:0] rd;
		int k;
		io_write(CTL, 8'h08);
		io_write(CMP, 8'h05);
		io_write(CNT, 8'hFD);
		io_write(FLG, 8'h03);
		io_write(CTL, 8'h09);
		rd = 8'h00;
		k = 0;
		while (rd[1:0] === 2'h0 && k < 50) begin
			io_read(FLG, rd);
			k++;
		end
		`CHK(rd[1:0], 2'h1)
		idle(10);
		io_read(FLG, rd);
		`CHK(rd[1:0], 2'h3)
		io_read(CNT, rd);
		`CHK(rd <= 8'h05, 1'b1)
	endtask

	// Rewrites compare, counter and control after the source change
	task t_async();
		logic [7:0] rd;
		logic [7:0] a;
		logic [7:0] b;
		io_write(CTL, 8'h00);
		io_write(CNT, 8'h00);
		io_write(STS, 8'h08);
		io_write(CMP, 8'h55);
		io_read(STS, rd);
		`CHK(rd, 8'h0A)
		io_read(CMP, rd);
		`CHK(rd, 8'h55)
		osc_enable = 1'b1;
		wait_idle();
		osc_enable = 1'b0;
		io_write(CNT, 8'h77);
		io_read(STS, rd);
		`CHK(rd, 8'h0C)
		io_read(CNT, rd);
		`CHK(rd, 8'h00)
		osc_enable = 1'b1;
		wait_idle();
		io_read(CNT, rd);
		`CHK(rd, 8'h77)
		osc_enable = 1'b0;
		io_write(CTL, 8'h01);
		io_read(STS, rd);
		`CHK(rd, 8'h09)
		osc_enable = 1'b1;
		wait_idle();
		io_read(CNT, a);
		idle(100);
		io_read(CNT, b);
		`CHK((b - a >= 8'h09) && (b - a <= 8'h0B), 1'b1)
	endtask

	// Main sequence
	initial begin
		repeat (16) @(posedge I_REF_CLK);
		#1;
		I_RESET_N = 1'b1;
		t_reset();
		t_ctc();
		t_prescale();
		t_pwm();
		t_miss();
		t_async();
		report_and_stop();
	end
endmodule

`default_nettype wire
